// >>> core/adcr_pkg.sv
// Shared constants for the converter serial result link.
package adcr_pkg;
    localparam int RES_W = 14;
    localparam int BUSY_BITS = RES_W + 1;
    localparam int NDEV_MAX = 4;
    localparam int RX_W = RES_W * NDEV_MAX;
    localparam int DEV_W = 3;
    localparam int BITS_W = 7;
    localparam int CNT_W = 16;
    localparam int FALL_W = 5;
    localparam int CLK_MHZ = 250;
    localparam int T_CONV_MIN_NS = 800;
    localparam int T_CONV_TYP_NS = 1000;
    localparam int T_CONV_MAX_NS = 1200;
    localparam int SCK_HALF = 6;

    function automatic int ns_to_cyc_up(input int ns);
        int cyc;
        cyc = (ns * CLK_MHZ + 999) / 1000;
        return (cyc < 1) ? 1 : cyc;
    endfunction
endpackage

// >>> core/adcr_link_if.sv
// Link wires between the converter end and the host end.
`timescale 1ns/100ps
interface adcr_link_if;
    logic sck;
    logic convert_start;
    logic select_chain_input;
    logic serial_result_out_o;
    logic serial_result_out_oe_n;
    logic serial_result_out_i;

    // Released line reads high through the pull-up.
    assign serial_result_out_i = serial_result_out_oe_n ? 1'b1 : serial_result_out_o;

    modport dev (
        input sck,
        input convert_start,
        input select_chain_input,
        output serial_result_out_o,
        output serial_result_out_oe_n
    );

    modport host (
        output sck,
        output convert_start,
        output select_chain_input,
        input serial_result_out_i
    );
endinterface

// >>> core/adcr_dev.sv
// Converter end: conversion timing, mode choice and serial result output.
`timescale 1ns/100ps
// What this block and the host do
// [R1] Start rise with select high: convert, release.
// [R2] Host holds start high through read.
// [R3] Select and start low: drive output low.
// [R4] Host returns select high to avoid busy.
// [R5] Host drops select early to get busy.
// [R6] No busy: MSB appears when select low.
// [R7] Further bits shift on falling clock edges.
// [R8] No busy: release at 14th fall or select.
// [R9] Busy: output driven low at conversion end.
// [R10] Busy: MSB first, release 15th fall.
// [R11] Start rise, clock low: chain, no busy.
// [R12] Host holds start high in chain mode.
// [R13] Chain no busy: MSB out at completion.
// [R14] Chain: serial input enters shift tail.
// [R15] Host gives fourteen clocks per converter.
// [R16] Start rise, clock high: chain with busy.
// [R17] Near end goes high when all done.
// [R18] Host gives fourteen per converter plus one.
// [R19] After conversion, idle until next start.
// [R20] Host may capture on falling edge.
// [R21] Select level at start picks the mode.
// [R22] Started conversion always runs to completion.
// [R23] Chain busy high needs own done, input high.
// [R24] Conversion length is a parameter.
module adcr_dev
    import adcr_pkg::*;
#(
    parameter int CONV_NS = T_CONV_TYP_NS
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [RES_W-1:0] SAMPLE,
    output logic CONVERTING,
    adcr_link_if.dev LINK
);
    // [R24] Conversion length set
    localparam int CONV_CYC = ns_to_cyc_up(CONV_NS);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
    localparam logic [FALL_W-1:0] LAST_PLAIN = FALL_W'(RES_W - 1);
    localparam logic [FALL_W-1:0] LAST_BUSY = FALL_W'(BUSY_BITS - 1);

    typedef enum logic [2:0] {
        ST_ACQ,
        ST_CONV,
        ST_WAIT_SEL,
        ST_SHIFT,
        ST_CHAIN
    } adcr_dev_state_t;

    adcr_dev_state_t state_reg;
    logic fall_tgl_reg;
    logic sdi_cap_reg;
    logic [2:0] fall_sync_reg;
    logic [2:0] cnv_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic [1:0] sck_sync_reg;
    logic chain_reg;
    logic busy_reg;
    logic [CNT_W-1:0] conv_cnt_reg;
    logic [RES_W-1:0] result_reg;
    logic [RES_W-1:0] sr_reg;
    logic hdr_reg;
    logic [FALL_W-1:0] fall_cnt_reg;
    logic sdo_o_reg;
    logic sdo_oe_n_reg;
    logic fall_evt;
    logic cnv_s;
    logic cnv_rise;
    logic sdi_s;
    logic sck_s;
    logic start;
    logic conv_end;
    logic cs_busy_now;
    logic last_fall;
    logic out_bit;

    // Each falling edge flips a toggle and catches the upstream bit.
    // The link clock may rest during reset, so this domain clears at once.
    always_ff @(negedge LINK.sck or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            fall_tgl_reg <= 1'b0;
            sdi_cap_reg <= 1'b0;
        end
        else
        begin
            fall_tgl_reg <= ~fall_tgl_reg;
            // [R14] Upstream bit capture
            sdi_cap_reg <= LINK.select_chain_input;
        end
    end

    // Pins and the toggle pass two flip-flops before logic reads them, except the upstream bit caught on the falling edge.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            fall_sync_reg <= 3'h0;
            cnv_sync_reg <= 3'h0;
            sdi_sync_reg <= 2'h0;
            sck_sync_reg <= 2'h0;
        end
        else
        begin
            fall_sync_reg <= {fall_sync_reg[1:0], fall_tgl_reg};
            cnv_sync_reg <= {cnv_sync_reg[1:0], LINK.convert_start};
            sdi_sync_reg <= {sdi_sync_reg[0], LINK.select_chain_input};
            sck_sync_reg <= {sck_sync_reg[0], LINK.sck};
        end
    end

    assign fall_evt = fall_sync_reg[2] ^ fall_sync_reg[1];
    assign cnv_s = cnv_sync_reg[1];
    assign cnv_rise = cnv_sync_reg[1] & ~cnv_sync_reg[2];
    assign sdi_s = sdi_sync_reg[1];
    assign sck_s = sck_sync_reg[1];
    // [R22] Start ignored mid-conversion
    assign start = cnv_rise && (state_reg != ST_CONV);
    assign conv_end = (state_reg == ST_CONV) && (conv_cnt_reg == CONV_LAST);
    // [R9] Busy chosen at end
    assign cs_busy_now = !sdi_s || !cnv_s;
    assign last_fall = fall_evt && (fall_cnt_reg == (busy_reg ? LAST_BUSY : LAST_PLAIN));
    // [R23] Busy bit follows upstream
    assign out_bit = hdr_reg ? (chain_reg & sdi_s) : sr_reg[RES_W-1];

    // Sequencing of conversion and readback.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= ST_ACQ;
        end
        else if (start)
        begin
            // [R1] Conversion begins
            state_reg <= ST_CONV;
        end
        else
        begin
            case (state_reg)
                ST_CONV:
                begin
                    if (conv_end)
                    begin
                        if (chain_reg)
                        begin
                            state_reg <= ST_CHAIN;
                        end
                        else if (cs_busy_now)
                        begin
                            state_reg <= ST_SHIFT;
                        end
                        else
                        begin
                            state_reg <= ST_WAIT_SEL;
                        end
                    end
                end
                ST_WAIT_SEL:
                begin
                    // [R6] Select opens output
                    if (!sdi_s)
                    begin
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    // [R8] [R10] Release point
                    if (sdi_s || last_fall)
                    begin
                        state_reg <= ST_ACQ;
                    end
                end
                ST_CHAIN:
                begin
                    if (!cnv_s)
                    begin
                        state_reg <= ST_ACQ;
                    end
                end
                default:
                begin
                    state_reg <= ST_ACQ;
                end
            endcase
        end
    end

    // Mode picked at the start edge; busy option there in chain mode, at conversion end otherwise.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            chain_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else if (start)
        begin
            // [R21] Mode from select
            chain_reg <= !sdi_s;
            // [R11] [R16] Busy from clock
            busy_reg <= !sdi_s && sck_s;
        end
        else if (conv_end && !chain_reg)
        begin
            busy_reg <= cs_busy_now;
        end
    end

    // Conversion timer and sampled value.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            conv_cnt_reg <= '0;
            result_reg <= '0;
        end
        else if (start)
        begin
            conv_cnt_reg <= '0;
            result_reg <= SAMPLE;
        end
        else if (state_reg == ST_CONV)
        begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
        end
    end

    // Result shift register, start bit and falling edge count.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            sr_reg <= '0;
            hdr_reg <= 1'b0;
            fall_cnt_reg <= '0;
        end
        else if (conv_end)
        begin
            // [R13] Result loaded
            sr_reg <= result_reg;
            hdr_reg <= chain_reg ? busy_reg : cs_busy_now;
            fall_cnt_reg <= '0;
        end
        else if (fall_evt && ((state_reg == ST_SHIFT) || (state_reg == ST_CHAIN)))
        begin
            fall_cnt_reg <= fall_cnt_reg + 1'b1;
            if (hdr_reg)
            begin
                hdr_reg <= 1'b0;
            end
            else
            begin
                // [R7] [R14] Shift on fall
                sr_reg <= {sr_reg[RES_W-2:0], chain_reg & sdi_cap_reg};
            end
        end
    end

    // Output pin drive.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            sdo_o_reg <= 1'b0;
            sdo_oe_n_reg <= 1'b1;
        end
        else if ((state_reg == ST_SHIFT) || (state_reg == ST_CHAIN))
        begin
            // [R17] Data or busy level
            sdo_o_reg <= out_bit;
            sdo_oe_n_reg <= 1'b0;
        end
        else if ((state_reg == ST_CONV) && chain_reg)
        begin
            sdo_o_reg <= 1'b0;
            sdo_oe_n_reg <= 1'b0;
        end
        else if (!sdi_s && !cnv_s)
        begin
            // [R3] Forced low
            sdo_o_reg <= 1'b0;
            sdo_oe_n_reg <= 1'b0;
        end
        else
        begin
            sdo_o_reg <= 1'b0;
            sdo_oe_n_reg <= 1'b1;
        end
    end

    assign LINK.serial_result_out_o = sdo_o_reg;
    assign LINK.serial_result_out_oe_n = sdo_oe_n_reg;
    // [R19] Idle outside conversion
    assign CONVERTING = (state_reg == ST_CONV);
endmodule

// >>> core/adcr_host.sv
// Host end: starts conversions, makes the serial clock and reads results.
`timescale 1ns/100ps
module adcr_host
    import adcr_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic START,
    input wire logic CHAIN_MODE,
    input wire logic BUSY_MODE,
    input wire logic [DEV_W-1:0] NUM_DEV,
    output logic READY,
    output logic RX_VALID,
    output logic [RX_W-1:0] RX_DATA,
    adcr_link_if.host LINK
);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(SCK_HALF - 1);
    localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(ns_to_cyc_up(T_CONV_MAX_NS) - 1);

    typedef enum logic [2:0] {
        H_IDLE,
        H_SETUP,
        H_ARM,
        H_WAIT,
        H_LEAD,
        H_HI,
        H_LO,
        H_END
    } adcr_host_state_t;

    adcr_host_state_t st_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic sck_reg;
    logic cnv_reg;
    logic sdi_reg;
    logic chain_reg;
    logic busy_reg;
    logic [BITS_W-1:0] nbits_reg;
    logic [BITS_W-1:0] bits_reg;
    logic [RX_W-1:0] rx_reg;
    logic valid_reg;
    logic [1:0] sdo_sync_reg;
    logic sdo_s;
    logic half_done;
    logic sample_now;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            sdo_sync_reg <= 2'h3;
        end
        else
        begin
            sdo_sync_reg <= {sdo_sync_reg[0], LINK.serial_result_out_i};
        end
    end

    assign sdo_s = sdo_sync_reg[1];
    assign half_done = (cnt_reg == HALF_LAST);
    assign sample_now = (st_reg == H_HI) && half_done;

    // Link sequencing; the serial clock rests low in reset and idle.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            st_reg <= H_IDLE;
            cnt_reg <= '0;
            sck_reg <= 1'b0;
            cnv_reg <= 1'b0;
            sdi_reg <= 1'b1;
            chain_reg <= 1'b0;
            busy_reg <= 1'b0;
            nbits_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
            case (st_reg)
                H_IDLE:
                begin
                    sck_reg <= 1'b0;
                    cnt_reg <= '0;
                    if (START)
                    begin
                        chain_reg <= CHAIN_MODE;
                        busy_reg <= BUSY_MODE;
                        // [R15] [R18] Clocks per frame
                        nbits_reg <= BITS_W'((CHAIN_MODE ? int'(NUM_DEV) : 1) * RES_W
                            + (BUSY_MODE ? 1 : 0));
                        sck_reg <= CHAIN_MODE & BUSY_MODE;
                        // [R4] Select stays high
                        sdi_reg <= !CHAIN_MODE;
                        st_reg <= H_SETUP;
                    end
                end
                H_SETUP:
                begin
                    if (half_done)
                    begin
                        cnv_reg <= 1'b1;
                        cnt_reg <= '0;
                        st_reg <= H_ARM;
                    end
                end
                H_ARM:
                begin
                    if (half_done)
                    begin
                        sck_reg <= 1'b0;
                        cnt_reg <= '0;
                        st_reg <= H_WAIT;
                        if (busy_reg)
                        begin
                            // [R5] Select dropped early
                            sdi_reg <= chain_reg;
                        end
                    end
                end
                H_WAIT:
                begin
                    if (busy_reg ? (sdo_s == chain_reg) : (cnt_reg == WAIT_LAST))
                    begin
                        sdi_reg <= busy_reg & chain_reg;
                        cnt_reg <= '0;
                        st_reg <= H_LEAD;
                    end
                end
                H_LEAD, H_LO:
                begin
                    if (half_done)
                    begin
                        sck_reg <= 1'b1;
                        cnt_reg <= '0;
                        st_reg <= H_HI;
                    end
                end
                H_HI:
                begin
                    if (half_done)
                    begin
                        sck_reg <= 1'b0;
                        cnt_reg <= '0;
                        st_reg <= (bits_reg == nbits_reg - 1'b1) ? H_END : H_LO;
                    end
                end
                H_END:
                begin
                    // [R2] [R12] Start held through read
                    if (half_done)
                    begin
                        cnv_reg <= 1'b0;
                        sdi_reg <= !chain_reg;
                        st_reg <= H_IDLE;
                    end
                end
                default:
                begin
                    st_reg <= H_IDLE;
                end
            endcase
        end
    end

    // Bits are taken as the clock falls; a busy start bit is dropped.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            bits_reg <= '0;
            rx_reg <= '0;
            valid_reg <= 1'b0;
        end
        else
        begin
            valid_reg <= (st_reg == H_END) && half_done;
            if ((st_reg == H_IDLE) && START)
            begin
                bits_reg <= '0;
                rx_reg <= '0;
            end
            // [R20] Capture on fall
            else if (sample_now)
            begin
                bits_reg <= bits_reg + 1'b1;
                if (!(busy_reg && (bits_reg == '0)))
                begin
                    rx_reg <= {rx_reg[RX_W-2:0], sdo_s};
                end
            end
        end
    end

    assign LINK.sck = sck_reg;
    assign LINK.convert_start = cnv_reg;
    assign LINK.select_chain_input = sdi_reg;
    assign READY = (st_reg == H_IDLE);
    assign RX_VALID = valid_reg;
    assign RX_DATA = rx_reg;
endmodule

// >>> verif/adcr_link_chk.sv
// Concurrent checks on the link between the converter end and the host end.
`timescale 1ns/100ps
module adcr_link_chk
    import adcr_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic sck,
    input wire logic convert_start,
    input wire logic select_chain_input,
    input wire logic serial_result_out_o,
    input wire logic serial_result_out_oe_n
);
    logic cs_reg;
    logic sck_hi_reg;
    logic busy_reg;
    logic [9:0] since_reg;
    logic [4:0] falls_reg;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    // Keeps the mode and the cycles since the last start rise.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            cs_reg <= 1'b1;
            sck_hi_reg <= 1'b0;
            since_reg <= 10'h3ff;
        end
        else if ($rose(convert_start))
        begin
            cs_reg <= select_chain_input;
            sck_hi_reg <= sck;
            since_reg <= 10'h000;
        end
        else if (since_reg != 10'h3ff)
        begin
            since_reg <= since_reg + 10'h001;
        end
    end

    // Notes the busy form and counts falling clock edges of a select read.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || $rose(convert_start))
        begin
            busy_reg <= 1'b0;
            falls_reg <= 5'h00;
        end
        else
        begin
            if (since_reg == 10'h101 && !select_chain_input)
            begin
                busy_reg <= 1'b1;
            end
            if ($fell(sck) && cs_reg && !select_chain_input && since_reg > 10'h101
                && falls_reg != 5'h1f)
            begin
                falls_reg <= falls_reg + 5'h01;
            end
        end
    end

    conv_hiz_a:
        assert property (cs_reg && since_reg > 10'h008 && since_reg < 10'h0f5
            |-> serial_result_out_oe_n) else $error("output driven in conversion");
    idle_low_a:
        assert property ((!select_chain_input && !convert_start) [*8]
            |-> !serial_result_out_oe_n && !serial_result_out_o)
        else $error("output not driven low when idle");
    select_msb_a:
        assert property ($fell(select_chain_input) && cs_reg && convert_start
            && since_reg > 10'h118 |-> ##[2:6] !serial_result_out_oe_n)
        else $error("no drive after select fell");
    release_14_a:
        assert property ($fell(sck) && cs_reg && !busy_reg && !select_chain_input
            && since_reg > 10'h101 && falls_reg == 5'h0d |-> ##[2:6] serial_result_out_oe_n)
        else $error("no release after 14 falls");
    busy_low_a:
        assert property (cs_reg && !select_chain_input && since_reg == 10'h101
            |-> !serial_result_out_oe_n && !serial_result_out_o)
        else $error("busy level missing at conversion end");
    release_15_a:
        assert property ($fell(sck) && cs_reg && busy_reg && !select_chain_input
            && falls_reg == 5'h0e |-> ##[2:6] serial_result_out_oe_n)
        else $error("no release after 15 falls");
    chain_msb_a:
        assert property (!cs_reg && !sck_hi_reg && since_reg == 10'h101
            |-> !serial_result_out_oe_n) else $error("chain output not driven");
    chain_busy_a:
        assert property (!cs_reg && sck_hi_reg && since_reg == 10'h101
            |-> !serial_result_out_oe_n && serial_result_out_o)
        else $error("chain busy level not high");
    chain_conv_a:
        assert property (!cs_reg && since_reg > 10'h008 && since_reg < 10'h0f5
            |-> !serial_result_out_oe_n && !serial_result_out_o)
        else $error("chain output high in conversion");
endmodule

// >>> verif/adc_serial_readout_modes_tb_top.sv
// Self-checking bench joining the converter end and the host end.
`timescale 1ns/100ps
module adc_serial_readout_modes_tb_top
    import adcr_pkg::*;
#(
    parameter int CONV_NS = 1000
)
;
    localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
    logic clk;
    logic sys_rst;
    logic start;
    logic chain_mode;
    logic busy_mode;
    logic [DEV_W-1:0] num_dev;
    logic [RES_W-1:0] sample;
    logic converting;
    logic ready;
    logic rx_valid;
    logic [RX_W-1:0] rx_data;
    int errors;
    int n_tests;

    adcr_link_if link_if ();

    adcr_dev #(.CONV_NS(CONV_NS)) adcr_dev_inst (.CLK(clk), .SYS_RST(sys_rst),
        .SAMPLE(sample), .CONVERTING(converting), .LINK(link_if));

    adcr_host adcr_host_inst (.CLK(clk), .SYS_RST(sys_rst), .START(start),
        .CHAIN_MODE(chain_mode), .BUSY_MODE(busy_mode), .NUM_DEV(num_dev), .READY(ready),
        .RX_VALID(rx_valid), .RX_DATA(rx_data), .LINK(link_if));

    adcr_link_chk adcr_link_chk_inst (.CLK(clk), .SYS_RST(sys_rst), .sck(link_if.sck),
        .convert_start(link_if.convert_start), .select_chain_input(link_if.select_chain_input),
        .serial_result_out_o(link_if.serial_result_out_o),
        .serial_result_out_oe_n(link_if.serial_result_out_oe_n));

    initial
    begin
        clk = 1'b0;
        forever
        begin
            #2 clk = ~clk;
        end
    end

    task automatic check_data(input logic [RX_W-1:0] got, input logic [RX_W-1:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        n_tests++;
        if (got != exp)
        begin
            errors++;
            $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", n_tests, errors);
        if (errors == 0 && n_tests > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Runs one frame, with an optional refused start, and checks its outcome.
    task automatic run_frame(input string name, input logic chain, input logic busy,
        input logic [DEV_W-1:0] ndev, input logic [RES_W-1:0] smp,
        input logic [RX_W-1:0] exp, input logic poke);
        int conv_cnt;
        int valid_cnt;
        int guard;
        logic [RX_W-1:0] mask;
        conv_cnt = 0;
        valid_cnt = 0;
        guard = 0;
        mask = {RX_W{1'b1}} >> (RX_W - RES_W * int'(ndev));
        while (ready !== 1'b1 && guard < 100)
        begin
            @(posedge clk);
            #1;
            guard++;
        end
        sample = smp;
        chain_mode = chain;
        busy_mode = busy;
        num_dev = ndev;
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
        guard = 0;
        while (valid_cnt == 0 && guard < 3000)
        begin
            @(posedge clk);
            #1;
            guard++;
            if (converting === 1'b1)
                conv_cnt++;
            if (rx_valid === 1'b1)
                valid_cnt++;
            if (poke && guard == 20)
                start = 1'b1;
            if (poke && guard == 21)
                start = 1'b0;
        end
        check_count(valid_cnt, 1);
        check_count(conv_cnt, CONV_CYC);
        check_data(rx_data & mask, exp);
        @(posedge clk);
        #1;
        check_flag(rx_valid, 1'b0);
        repeat (30) @(posedge clk);
        #1;
        check_flag(ready, 1'b1);
        $display("test %s done", name);
    endtask

    initial
    begin
        sys_rst = 1'b1;
        start = 1'b0;
        chain_mode = 1'b0;
        busy_mode = 1'b0;
        num_dev = 3'h1;
        sample = 14'h0000;
        errors = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check_flag(ready, 1'b1);
        run_frame("select", 1'b0, 1'b0, 3'h1, 14'h2000, {42'h0, 14'h2000}, 1'b1);
        run_frame("select_again", 1'b0, 1'b0, 3'h1, 14'h3ffe, {42'h0, 14'h3ffe}, 1'b0);
        run_frame("select_busy", 1'b0, 1'b1, 3'h1, 14'h0001, {42'h0, 14'h0001}, 1'b0);
        run_frame("chain", 1'b1, 1'b0, 3'h1, 14'h3fff, {42'h0, 14'h3fff}, 1'b0);
        run_frame("chain_busy", 1'b1, 1'b1, 3'h1, 14'h2aaa, {42'h0, 14'h2aaa}, 1'b0);
        run_frame("chain_two", 1'b1, 1'b0, 3'h2, 14'h1555,
            {28'h0, 14'h1555, 14'h0000}, 1'b0);
        give_verdict();
    end

    initial
    begin
        #100000;
        errors++;
        give_verdict();
    end
endmodule
